/* File: logic/flash_mode_reset_power_cmds.v */
// command interpreter for quad mode exit, software reset and ultra-deep power-down
`timescale 1ns/10ps
`include "flash_cmd_map.vh"

// ***************************************************
// overview
// ***************************************************
// the host pins are sampled by the system clock, so the link clock
// must stay well below a quarter of it; 80 ns link periods are safe.
// an opcode is the first eight bits of a frame and is acted on only
// when chip select rises, once the frame length is known.
// the power state machine owns every timed interval; while it is
// outside standby any frame that opens is dropped as a whole.
// the volatile settings are loaded by neighbouring logic through
// cfg_load_i and only in standby, so a recovery cannot be undone.
// limitation: dual and quad spi data phases are not decoded here,
// only single-line opcodes in spi mode and nibbles in quad mode.

module flash_mode_reset_power_cmds #(
  parameter RESET_CYC = (`RESET_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter ENTRY_CYC = `ULTRA_ENTRY_NS / `CLK_PERIOD_NS,
  parameter WAKE_CYC  = (`WAKE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter EXIT_CYC  = `ULTRA_EXIT_NS / `CLK_PERIOD_NS,
  parameter CW        = 14
) (
  // system
  input  wire       sys_clk_i,
  input  wire       sys_rst_i,
  // serial link pins
  input  wire       sel_n_i,
  input  wire       sclk_i,
  input  wire [3:0] io_i,
  // device status inputs
  input  wire       busy_i,
  input  wire       deep_pd_i,
  input  wire       quad_enable_bit_i,
  input  wire       set_wel_i,
  input  wire       set_sus_i,
  input  wire [7:0] set_param_i,
  input  wire [2:0] set_wrap_i,
  input  wire       cfg_load_i,
  // state outputs
  output reg        quad_instruction_mode_o,
  output reg        write_enable_latch_o,
  output reg        suspend_flag_o,
  output reg  [7:0] read_parameter_bits_o,
  output reg  [2:0] wrap_setting_bits_o,
  output reg        reset_enabled_o,
  output reg        abort_op_o,
  output reg        resetting_o,
  output reg        ultra_deep_o,
  output reg        standby_o
);

  // ***************************************************
  // power states, one-hot
  // ***************************************************
  // standby, reset recovery, entry wait, ultra-deep, exit wait
  // one-hot so that standby is a single bit that gating can test
  localparam ST_STBY  = 5'h01;
  localparam ST_RST   = 5'h02;
  localparam ST_ENTER = 5'h04;
  localparam ST_UDPD  = 5'h08;
  localparam ST_EXIT  = 5'h10;

  // ***************************************************
  // pin synchronisers and clock edge
  // ***************************************************
  reg  [5:0] s1_r;
  reg  [5:0] s2_r;
  reg        sclk_d_r;
  reg        sel_d_r;
  // two flops per pin; only s2 is looked at
  // the pins are asynchronous to sys_clk_i, so the first stage may go
  // metastable; nothing but the second stage ever reads it
  always @(posedge sys_clk_i) begin
    s1_r <= {sel_n_i, sclk_i, io_i};
    s2_r <= s1_r;
  end
  wire       sel_n   = s2_r[5];
  wire       sclk    = s2_r[4];
  wire [3:0] io      = s2_r[3:0];
  // edge detectors on the synchronised pins; the delayed copies reset
  // high so that no false rising clock edge follows reset
  wire       rise    = sclk & ~sclk_d_r;
  wire       sel_up  = sel_n & ~sel_d_r;
  wire       sel_dn  = ~sel_n & sel_d_r;

  // ***************************************************
  // opcode shifter
  // ***************************************************
  reg  [7:0] sh_r;
  reg  [4:0] bits_r;
  reg        got_r;   // first byte complete
  reg  [7:0] op_r;
  reg  [4:0] state_r;
  reg  [CW-1:0] cnt_r;
  reg        ign_r;   // frame began while busy in a timed state
  // spi shifts one bit from io[0]; quad mode one nibble, msb first
  // the step follows the mode, so the byte ends after 8 or 2 edges
  wire [7:0] sh_nxt = quad_instruction_mode_o ? {sh_r[3:0], io} : {sh_r[6:0], io[0]};
  wire [4:0] step   = quad_instruction_mode_o ? 5'h04 : 5'h01;
  wire [4:0] bits_nxt = bits_r + step;
  // multiple of eight bits at deselect
  wire       aligned = (bits_r[2:0] == 3'h0);

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sclk_d_r <= 1'b1;
      sel_d_r  <= 1'b1;
      sh_r     <= 8'h00;
      bits_r   <= 5'h00;
      got_r    <= 1'b0;
      op_r     <= 8'h00;
    end else begin
      sclk_d_r <= sclk;
      sel_d_r  <= sel_n;
      if (sel_dn) begin
        bits_r <= 5'h00;
        got_r  <= 1'b0;
      end else if (!sel_n && rise) begin
        sh_r <= sh_nxt;
        // count wraps modulo 16 past one byte; we only care about alignment
        bits_r <= {1'b0, bits_nxt[3:0]};
        if (!got_r && bits_nxt[3:0] == `BYTE_BITS) begin
          got_r <= 1'b1;
          op_r  <= sh_nxt;
        end
      end
    end
  end

  // ***************************************************
  // command decode and power state machine
  // ***************************************************
  // commands act at deselect; the whole frame is then known
  wire cmd_ok = sel_up & got_r & ~ign_r & state_r[0];
  // opcode matches, decoded once for the state machine
  wire is_rst_en  = (op_r == `OP_RESET_ENABLE);
  wire is_rst     = (op_r == `OP_RESET);
  wire is_exit_q  = (op_r == `OP_EXIT_QUAD);
  wire is_enter_q = (op_r == `OP_ENTER_QUAD);
  wire is_udpd    = (op_r == `OP_ULTRA_DEEP);

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      // standby after power cycle
      // the volatile settings here are also the defaults that an accepted reset restores
      state_r                 <= ST_STBY;
      cnt_r                   <= {CW{1'b0}};
      ign_r                   <= 1'b0;
      quad_instruction_mode_o <= 1'b0;
      write_enable_latch_o    <= 1'b0;
      suspend_flag_o          <= 1'b0;
      read_parameter_bits_o   <= `PARAM_DEFAULT;
      wrap_setting_bits_o     <= `WRAP_DEFAULT;
      reset_enabled_o         <= 1'b0;
      abort_op_o              <= 1'b0;
      resetting_o             <= 1'b0;
      ultra_deep_o            <= 1'b0;
      standby_o               <= 1'b1;
    end else begin
      abort_op_o <= 1'b0;
      // a frame opened outside standby is dropped whole
      // taken at the falling select, so a frame that spans the end
      // of an interval is still refused
      if (sel_dn) begin
        ign_r <= ~state_r[0];
      end
      // other logic loads volatile state only in standby
      // a command decoded in the same cycle wins, as it is assigned later
      if (cfg_load_i && state_r[0]) begin
        write_enable_latch_o  <= set_wel_i;
        suspend_flag_o        <= set_sus_i;
        read_parameter_bits_o <= set_param_i;
        wrap_setting_bits_o   <= set_wrap_i;
      end
      case (state_r)
        ST_STBY: begin
          if (cmd_ok) begin
            // any opcode other than reset enable cancels enable
            reset_enabled_o <= is_rst_en;
            // pair accepted in either mode
            // the enable is read before this frame overwrites it
            if (is_rst && reset_enabled_o) begin
              abort_op_o              <= 1'b1;
              quad_instruction_mode_o <= 1'b0;
              write_enable_latch_o    <= 1'b0;
              suspend_flag_o          <= 1'b0;
              read_parameter_bits_o   <= `PARAM_DEFAULT;
              wrap_setting_bits_o     <= `WRAP_DEFAULT;
              resetting_o             <= 1'b1;
              standby_o               <= 1'b0;
              cnt_r                   <= RESET_CYC[CW-1:0];
              state_r                 <= ST_RST;
            end else if (is_exit_q && quad_instruction_mode_o) begin
              // back to spi; latch, suspend, wrap kept
              quad_instruction_mode_o <= 1'b0;
            end else if (is_enter_q && !quad_instruction_mode_o) begin
              // only with quad enable set; wrap returns to default
              if (quad_enable_bit_i) begin
                quad_instruction_mode_o <= 1'b1;
                wrap_setting_bits_o     <= `WRAP_DEFAULT;
              end
            end else if (is_udpd && deep_pd_i && !busy_i && aligned) begin
              // entry from deep power-down; unaligned aborts; busy ignores
              standby_o <= 1'b0;
              cnt_r     <= ENTRY_CYC[CW-1:0];
              state_r   <= ST_ENTER;
            end
          end
        end
        ST_RST: begin
          // nothing accepted until recovery ends
          // cmd_ok is gated by standby, so frames here never decode
          if (cnt_r <= {{(CW-1){1'b0}}, 1'b1}) begin
            resetting_o <= 1'b0;
            standby_o   <= 1'b1;
            state_r     <= ST_STBY;
          end
          cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
        end
        ST_ENTER: begin
          // in ultra-deep within entry time
          // the counter is left at zero for the wake pulse measurement
          if (cnt_r <= {{(CW-1){1'b0}}, 1'b1}) begin
            ultra_deep_o <= 1'b1;
            cnt_r        <= {CW{1'b0}};
            state_r      <= ST_UDPD;
          end else begin
            cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
          end
        end
        ST_UDPD: begin
          // opcodes never decoded; only a long select pulse counts
          // dummy bytes in the pulse are discarded
          // the pulse length saturates, so a very long low never wraps
          if (sel_dn) begin
            cnt_r <= {CW{1'b0}};
          end else if (!sel_n && cnt_r != {CW{1'b1}}) begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
          end
          if (sel_up && cnt_r >= WAKE_CYC[CW-1:0]) begin
            cnt_r   <= EXIT_CYC[CW-1:0];
            state_r <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          // standby within exit time
          // a select that falls here marks its whole frame as refused
          if (cnt_r <= {{(CW-1){1'b0}}, 1'b1}) begin
            ultra_deep_o <= 1'b0;
            standby_o    <= 1'b1;
            state_r      <= ST_STBY;
          end
          cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
        end
        default: begin
          state_r <= ST_STBY;
        end
      endcase
    end
  end

  // ***************************************************
  // limitations
  // ***************************************************
  // the counters are CW bits wide; any timing parameter above
  // 2**CW - 1 cycles would wrap, so raise CW together with them.
  // the bit counter keeps only four bits after the first byte, which
  // is all that the byte alignment test of the entry command needs.
  // abort_op_o is a single-cycle request; the program and erase
  // engines must latch it themselves if they act on it later.
  // commands take effect about three cycles after the select pin
  // rises, because of the synchroniser and the edge detector.
  // the wake pulse is measured in system cycles after the
  // synchroniser, so its minimum is good to about two cycles.
  // busy_i and deep_pd_i are read as levels at the deciding cycle;
  // their owners must hold them steady across a whole frame.

endmodule

/* File: logic/flash_cmd_map.vh */
// opcodes, byte framing, register defaults and timing figures for the flash mode/reset/power command block
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// opcodes
`define OP_EXIT_QUAD     8'hff
`define OP_ENTER_QUAD    8'h38
`define OP_RESET_ENABLE  8'h66
`define OP_RESET         8'h99
`define OP_ULTRA_DEEP    8'h79

// byte framing and register defaults
`define BYTE_BITS        4'h8
`define WRAP_DEFAULT     3'h0
`define PARAM_DEFAULT    8'h00

// times in ns and system clock period in ns
`define CLK_PERIOD_NS    4
`define RESET_RECOVERY_NS 28000
`define ULTRA_ENTRY_NS   3000
`define WAKE_LOW_NS      200
`define ULTRA_EXIT_NS    10000

`endif

/* File: tb/host_link.sv */
// host-side serial link driver for the flash command block
`timescale 1ns/10ps
module host_link (
  // clock
  input  wire       clk_i,
  // link pins
  output reg        sel_n_o,
  output reg        sclk_o,
  output reg  [3:0] io_o
);
  integer i;
  // idle pins at time zero
  initial begin
    sel_n_o = 1'h1;
    sclk_o  = 1'h0;
    io_o    = 4'h5;
  end
  // msb first, rising edges
  // clock stands still outside frames; 84 ns link period
  task frame(input [7:0] b, input integer n, input q);
    begin
      @(posedge clk_i) sel_n_o <= 1'h0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk_i) io_o <= q ? (i[0] ? b[3:0] : b[7:4]) : {~io_o[3:1], b[7 - i % 8]};
        repeat (10) @(posedge clk_i);
        sclk_o <= 1'h1;
        repeat (10) @(posedge clk_i);
        sclk_o <= 1'h0;
      end
      @(posedge clk_i) sel_n_o <= 1'h1;
      io_o <= ~io_o; // released lines must not show the last bit
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule

/* File: tb/flash_cmds_sva.sv */
// assertions on the state outputs of the flash command block
`timescale 1ns/10ps
module flash_cmds_sva #(
  parameter RESET_CYC = 7000,
  parameter ENTRY_CYC = 750
) (
  // system
  input wire       sys_clk_i,
  input wire       sys_rst_i,
  // watched ports
  input wire       quad_enable_bit_i,
  input wire       quad_instruction_mode_o,
  input wire       write_enable_latch_o,
  input wire       suspend_flag_o,
  input wire [7:0] read_parameter_bits_o,
  input wire [2:0] wrap_setting_bits_o,
  input wire       reset_enabled_o,
  input wire       abort_op_o,
  input wire       resetting_o,
  input wire       ultra_deep_o,
  input wire       standby_o
);
  localparam int ENT_LO = ENTRY_CYC - 3;
  localparam int ENT_HI = ENTRY_CYC + 1;
  reg  [15:0] rcnt_r;
  wire [15:0] rcnt_nxt = resetting_o ? rcnt_r + 16'h1 : 16'h0;
  wire [14:0] vol = {quad_instruction_mode_o, write_enable_latch_o, suspend_flag_o,
                     read_parameter_bits_o, wrap_setting_bits_o, reset_enabled_o};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // length of recovery, so a wrong count shows at its end
  always @(posedge sys_clk_i) begin
    rcnt_r <= sys_rst_i ? 16'h0 : rcnt_nxt;
  end
  // entry begins: standby drops without a reset behind it
  sequence s_entry;
    $fell(standby_o) ##1 !resetting_o;
  endsequence
  property p_abort_pulse; abort_op_o |=> !abort_op_o; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort held");
  property p_abort_clr; abort_op_o |-> ##[0:1] (resetting_o && vol == 15'h0); endproperty
  a_abort_clr: assert property (p_abort_clr) else $error("reset kept state");
  property p_rst_len;
    $fell(resetting_o) && !$past(sys_rst_i) |-> rcnt_r >= RESET_CYC - 2 && rcnt_r <= RESET_CYC + 1;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("recovery length off");
  property p_rec_quiet;
    resetting_o && $past(resetting_o) |-> !standby_o && vol == 15'h0;
  endproperty
  a_rec_quiet: assert property (p_rec_quiet) else $error("command in recovery");
  property p_ud_quiet; ultra_deep_o && $past(ultra_deep_o) |-> $stable(vol); endproperty
  a_ud_quiet: assert property (p_ud_quiet) else $error("command in ultra-deep");
  property p_entry; s_entry |-> ##[ENT_LO:ENT_HI] ultra_deep_o; endproperty
  a_entry: assert property (p_entry) else $error("entry time off");
  property p_excl; standby_o |-> !ultra_deep_o && !resetting_o; endproperty
  a_excl: assert property (p_excl) else $error("standby overlaps");
  property p_quad_qe; $rose(quad_instruction_mode_o) |-> quad_enable_bit_i; endproperty
  a_quad_qe: assert property (p_quad_qe) else $error("quad without enable");
endmodule
bind flash_mode_reset_power_cmds flash_cmds_sva #(.RESET_CYC(RESET_CYC), .ENTRY_CYC(ENTRY_CYC))
  u_sva (.sys_clk_i, .sys_rst_i, .quad_enable_bit_i, .quad_instruction_mode_o,
  .write_enable_latch_o, .suspend_flag_o, .read_parameter_bits_o, .wrap_setting_bits_o,
  .reset_enabled_o, .abort_op_o, .resetting_o, .ultra_deep_o, .standby_o);

/* File: tb/tb_top.sv */
// self-checking bench for the flash command block
`timescale 1ns/10ps
module tb_top;
  reg        sys_clk_i = 1'h0;
  reg        sys_rst_i = 1'h1;
  reg        busy, deep, qe, wl, ss, ld;
  reg  [7:0] pr;
  reg  [2:0] wp;
  wire       sel_n, sclk, q, w, s, ren, ab, rs, ud, sb;
  wire [3:0] io;
  wire [7:0] p;
  wire [2:0] wr;
  integer    failures = 0;
  integer    n_compared = 0;
  integer    t, m;
  // 250 MHz clock
  always #2 sys_clk_i = ~sys_clk_i;
  host_link host (.clk_i(sys_clk_i), .sel_n_o(sel_n), .sclk_o(sclk), .io_o(io));
  // short counts keep the run brief
  flash_mode_reset_power_cmds #(.RESET_CYC(20), .ENTRY_CYC(10), .WAKE_CYC(8), .EXIT_CYC(20)) dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sel_n_i(sel_n), .sclk_i(sclk), .io_i(io),
    .busy_i(busy), .deep_pd_i(deep), .quad_enable_bit_i(qe), .set_wel_i(wl), .set_sus_i(ss),
    .set_param_i(pr), .set_wrap_i(wp), .cfg_load_i(ld), .quad_instruction_mode_o(q),
    .write_enable_latch_o(w), .suspend_flag_o(s), .read_parameter_bits_o(p),
    .wrap_setting_bits_o(wr), .reset_enabled_o(ren), .abort_op_o(ab), .resetting_o(rs),
    .ultra_deep_o(ud), .standby_o(sb));
  // state word: quad, wel, sus, param, wrap, then enabled/recovery/ultra/standby
  task chk(input [17:0] e);
    begin
      n_compared = n_compared + 1;
      if ({q, w, s, p, wr, ren, rs, ud, sb} !== e) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h want %h", $time, {q, w, s, p, wr, ren, rs, ud, sb}, e);
      end
    end
  endtask
  task cfg(input a, input b, input [7:0] c, input [2:0] d);
    begin
      @(posedge sys_clk_i) {wl, ss, pr, wp, ld} <= {a, b, c, d, 1'h1};
      @(posedge sys_clk_i) ld <= 1'h0;
      @(posedge sys_clk_i);
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // bounded wait for standby
  task wait_sb;
    begin
      for (t = 0; t < 200 && sb !== 1'h1; t = t + 1) @(posedge sys_clk_i);
      if (t == 200) begin
        failures = failures + 1;
        $display("wrong value at %0t: no standby", $time);
        finish_test;
      end
    end
  endtask
  // main sequence; busy stays low around every reset pair
  initial begin
    {busy, deep, qe, wl, ss, pr, wp, ld} = 17'h0;
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    chk(18'h00001);
    cfg(1'h1, 1'h1, 8'ha5, 3'h5);
    @(posedge sys_clk_i) qe <= 1'h1;
    host.frame(8'h38, 8, 1'h0);
    chk({3'h7, 8'ha5, 3'h0, 4'h1});
    cfg(1'h1, 1'h1, 8'ha5, 3'h6);
    host.frame(8'hff, 2, 1'h1);
    chk({3'h3, 8'ha5, 3'h6, 4'h1});
    @(posedge sys_clk_i) qe <= 1'h0;
    host.frame(8'h38, 8, 1'h0);
    chk({3'h3, 8'ha5, 3'h6, 4'h1});
    @(posedge sys_clk_i) qe <= 1'h1;
    for (m = 0; m < 2; m = m + 1) begin
      cfg(1'h1, 1'h1, 8'ha5, 3'h6);
      if (m == 1) host.frame(8'h38, 8, 1'h0);
      host.frame(8'h66, 8 - 6 * m, m[0]);
      host.frame(8'h05, 8 - 6 * m, m[0]);
      chk({m[0], 2'h3, 8'ha5, m[0] ? 3'h0 : 3'h6, 4'h1});
      host.frame(8'h66, 8 - 6 * m, m[0]);
      chk({m[0], 2'h3, 8'ha5, m[0] ? 3'h0 : 3'h6, 4'h9});
      host.frame(8'h99, 8 - 6 * m, m[0]);
      chk(18'h00004);
      host.frame(8'h66, 8, 1'h0);
      wait_sb;
      chk(18'h00001);
    end
    {deep, busy} <= 2'h3;
    host.frame(8'h79, 8, 1'h0);
    chk(18'h00001);
    busy <= 1'h0;
    host.frame(8'h79, 7, 1'h0);
    host.frame(8'h79, 12, 1'h0);
    chk(18'h00001);
    host.frame(8'h79, 16, 1'h0);
    repeat (10) @(posedge sys_clk_i);
    chk(18'h00002);
    host.frame(8'h66, 8, 1'h0);
    chk(18'h00002);
    host.frame(8'h66, 8, 1'h0);
    wait_sb;
    chk(18'h00001);
    deep <= 1'h0;
    host.frame(8'h79, 8, 1'h0);
    chk(18'h00001);
    finish_test;
  end
endmodule
